// ---- design/safety_status_fsm_led.sv ----
// Top state machine, common status flags and status LED of the safety module.
//
// Behaviour
// - After reset, start in first initialisation running self-tests.
// - Set valid only when all parameters validated and set marked validated.
// - Delivery: all parameters validated, set not validated, delivery id set.
// - Unvalidated parameter, or unvalidated set without delivery id, leads to service and waits.
// - In service, safe outputs, stage enable and brake enable are held off.
// - After parameterisation: second initialisation, then link to basic unit.
// - Operation entered only without start-up errors and with valid set.
// - System error left only on cleared cause plus acknowledge, or restart.
// - In operation: ready without requests, requested once any function asks.
// - Requested advances to safe reached once drive reports safe condition.
// - Violation error in operation gives violated sub-state, left by acknowledge or by leaving operation.
// - Ready flag: no error above warning and no function requested.
// - Service flag: set invalid, session running or no set present.
// - Parameter checksum failure moves the machine to system error.
// - Function-requested flag high while at least one request stands.
// - Safe-reached flag: at least one request, all requested report safe.
// - System-error flag: non-violation error above warning pending, or machine in system error.
// - Violated flag: violation-category error above warning pending.
// - Warning flag: non-violation error configured as warning pending.
// - Power-stage flag follows the safe pulse-block driver supply state.
// - LED shows top priority: 7 red flash, 6 red, 5 yellow, 4 yellow flash.
// - Then 3 red/green, 2 green flash, 1 green, 0 dark; about 3 Hz.
`timescale 1ns/100ps
`include "ssf_map.svh"
module safety_status_fsm_led #(
  parameter int NUM_FUNC    = 8,
  parameter int HALF_CYCLES = `SSF_FLASH_HALF_CYCLES
) (
  input  wire logic                   clk_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   axi_awvalid_in,
  output logic                        axi_awready_out,
  input  wire logic [`SSF_ADDR_W-1:0] axi_awaddr_in,
  input  wire logic                   axi_wvalid_in,
  output logic                        axi_wready_out,
  input  wire logic [31:0]            axi_wdata_in,
  input  wire logic [3:0]             axi_wstrb_in,
  output logic                        axi_bvalid_out,
  input  wire logic                   axi_bready_in,
  output logic [1:0]                  axi_bresp_out,
  input  wire logic                   axi_arvalid_in,
  output logic                        axi_arready_out,
  input  wire logic [`SSF_ADDR_W-1:0] axi_araddr_in,
  output logic                        axi_rvalid_out,
  input  wire logic                   axi_rready_in,
  output logic [31:0]                 axi_rdata_out,
  output logic [1:0]                  axi_rresp_out,
  input  wire logic                   selftest_done_in,
  input  wire logic                   selftest_fail_in,
  input  wire logic                   param_present_in,
  input  wire logic                   all_params_validated_in,
  input  wire logic                   set_validated_in,
  input  wire logic                   delivery_id_in,
  input  wire logic                   checksum_fail_in,
  input  wire logic                   param_session_in,
  input  wire logic                   init2_done_in,
  input  wire logic                   comm_up_in,
  input  wire logic                   sys_fault_in,
  input  wire logic                   err_above_warn_in,
  input  wire logic                   err_warn_in,
  input  wire logic                   viol_err_above_warn_in,
  input  wire logic [NUM_FUNC-1:0]    func_request_in,
  input  wire logic [NUM_FUNC-1:0]    func_safe_in,
  input  wire logic                   pulse_block_enabled_in,
  output logic                        ready_no_request_flag_out,
  output logic                        service_needed_flag_out,
  output logic                        function_requested_flag_out,
  output logic                        safe_state_reached_flag_out,
  output logic                        system_error_flag_out,
  output logic                        condition_violated_flag_out,
  output logic                        warning_flag_out,
  output logic                        power_stage_enable_flag_out,
  output logic                        safe_outputs_off_out,
  output logic                        stage_enable_permit_out,
  output logic                        brake_enable_permit_out,
  output logic [2:0]                  led_prio_out,
  output logic                        led_red_out,
  output logic                        led_green_out
);

  ssf_pkg::top_state_t state_q;
  ssf_pkg::sub_state_t sub_q;
  logic [7:0]          flags_q;
  logic [2:0]          prio_q;
  logic                red_q;
  logic                green_q;
  logic                session_q;
  logic                ack_q;
  logic                restart_q;
  logic                flash_phase;
  logic                any_req;
  logic                all_safe;
  logic                set_valid;
  logic                delivery_cond;
  logic                fault;
  logic                session_end;

  logic                      aw_held_q;
  logic                      w_held_q;
  logic [`SSF_ADDR_W-1:0]    awaddr_q;
  logic [31:0]               wdata_q;
  logic [3:0]                wstrb_q;
  logic                      bvalid_q;
  logic [1:0]                bresp_q;
  logic                      rvalid_q;
  logic [31:0]               rdata_q;
  logic [1:0]                rresp_q;
  logic                      do_write;

  function automatic logic is_reg(input logic [`SSF_ADDR_W-1:0] a,
                                  input logic [`SSF_ADDR_W-1:0] off);
    is_reg = ({a[`SSF_ADDR_W-1:2], 2'h0} == off);
  endfunction

  function automatic logic [2:0] led_prio(input logic [7:0] f);
    if (f[4])
      led_prio = `SSF_PRIO_ERROR;
    else if (f[5] && f[2])
      led_prio = `SSF_PRIO_VIOLATED;
    else if (f[3] && f[2])
      led_prio = `SSF_PRIO_SAFE;
    else if (f[2])
      led_prio = `SSF_PRIO_REQUESTED;
    else if (f[1] && f[7])
      led_prio = `SSF_PRIO_DELIVERY;
    else if (f[1])
      led_prio = `SSF_PRIO_SERVICE;
    else if (f[0] && f[7])
      led_prio = `SSF_PRIO_READY;
    else
      led_prio = `SSF_PRIO_OFF;
  endfunction

  assign set_valid     = all_params_validated_in && set_validated_in;
  assign delivery_cond = all_params_validated_in && !set_validated_in &&
                         delivery_id_in;
  assign any_req       = |func_request_in;
  assign all_safe      = &(func_safe_in | ~func_request_in);
  assign fault         = sys_fault_in || checksum_fail_in;
  assign session_end   = session_q && !param_session_in;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in)
      session_q <= 1'b0;
    else
      session_q <= param_session_in;
  end

  // The machine moves on start-up, parameter, link and fault inputs and on acknowledge or restart; a fault wins over all but a restart
  // so that no path can slip into operation past a pending system error.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= ssf_pkg::ST_INIT1;
    end else if (restart_q) begin
      state_q <= ssf_pkg::ST_INIT1;
    end else if (fault && state_q != ssf_pkg::ST_SYS_ERROR) begin
      state_q <= ssf_pkg::ST_SYS_ERROR;
    end else begin
      case (state_q)
        ssf_pkg::ST_INIT1: begin
          if (selftest_fail_in)
            state_q <= ssf_pkg::ST_SYS_ERROR;
          else if (selftest_done_in)
            state_q <= ssf_pkg::ST_PARAM_CHECK;
        end
        ssf_pkg::ST_PARAM_CHECK: begin
          if (param_present_in && set_valid)
            state_q <= ssf_pkg::ST_INIT2;
          else if (param_present_in && delivery_cond)
            state_q <= ssf_pkg::ST_DELIVERY;
          else
            state_q <= ssf_pkg::ST_SERVICE;
        end
        ssf_pkg::ST_SERVICE: begin
          if (session_end)
            state_q <= ssf_pkg::ST_INIT2;
        end
        ssf_pkg::ST_DELIVERY: begin
          if (param_session_in)
            state_q <= ssf_pkg::ST_SERVICE;
        end
        ssf_pkg::ST_INIT2: begin
          if (init2_done_in)
            state_q <= ssf_pkg::ST_COMM;
        end
        ssf_pkg::ST_COMM: begin
          if (comm_up_in && param_present_in && set_valid)
            state_q <= ssf_pkg::ST_OPERATION;
          else if (comm_up_in)
            state_q <= ssf_pkg::ST_SERVICE;
        end
        ssf_pkg::ST_OPERATION: state_q <= ssf_pkg::ST_OPERATION;
        ssf_pkg::ST_SYS_ERROR: begin
          // Leave on cleared cause plus acknowledge.
          if (ack_q && !fault)
            state_q <= ssf_pkg::ST_INIT1;
        end
        default: state_q <= ssf_pkg::ST_INIT1;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || state_q != ssf_pkg::ST_OPERATION) begin
      sub_q <= ssf_pkg::SUB_READY;
    end else begin
      case (sub_q)
        ssf_pkg::SUB_VIOLATED: begin
          if (ack_q)
            sub_q <= ssf_pkg::SUB_READY;
        end
        default: begin
          if (viol_err_above_warn_in)
            sub_q <= ssf_pkg::SUB_VIOLATED;
          else if (!any_req)
            sub_q <= ssf_pkg::SUB_READY;
          else if (all_safe)
            sub_q <= ssf_pkg::SUB_SAFE_REACHED;
          else
            sub_q <= ssf_pkg::SUB_REQUESTED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flags_q <= `SSF_FLAGS_RESET;
    end else begin
      flags_q[0] <= !(err_above_warn_in || viol_err_above_warn_in) &&
                    !any_req;
      flags_q[1] <= !set_valid || param_session_in || !param_present_in;
      flags_q[2] <= any_req;
      flags_q[3] <= any_req && all_safe;
      flags_q[4] <= err_above_warn_in || state_q == ssf_pkg::ST_SYS_ERROR;
      flags_q[5] <= viol_err_above_warn_in;
      flags_q[6] <= err_warn_in;
      flags_q[7] <= pulse_block_enabled_in;
    end
  end

  assign ready_no_request_flag_out   = flags_q[0];
  assign service_needed_flag_out     = flags_q[1];
  assign function_requested_flag_out = flags_q[2];
  assign safe_state_reached_flag_out = flags_q[3];
  assign system_error_flag_out       = flags_q[4];
  assign condition_violated_flag_out = flags_q[5];
  assign warning_flag_out            = flags_q[6];
  assign power_stage_enable_flag_out = flags_q[7];

  assign safe_outputs_off_out    = !(state_q == ssf_pkg::ST_OPERATION ||
                                     state_q == ssf_pkg::ST_DELIVERY);
  assign stage_enable_permit_out = !safe_outputs_off_out;
  assign brake_enable_permit_out = !safe_outputs_off_out;

  led_flasher #(
    .HALF_CYCLES (HALF_CYCLES)
  ) led_flasher_i (
    .clk_in          (clk_in),
    .sys_rst_in      (sys_rst_in),
    .flash_phase_out (flash_phase)
  );

  // The LED is diagnostic only, so colours two cycles behind the flags are fine.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prio_q  <= `SSF_PRIO_OFF;
      red_q   <= 1'b0;
      green_q <= 1'b0;
    end else begin
      prio_q <= led_prio(flags_q);
      case (prio_q)
        `SSF_PRIO_ERROR:     begin red_q <= flash_phase;  green_q <= 1'b0; end
        `SSF_PRIO_VIOLATED:  begin red_q <= 1'b1;         green_q <= 1'b0; end
        `SSF_PRIO_SAFE:      begin red_q <= 1'b1;         green_q <= 1'b1; end
        `SSF_PRIO_REQUESTED: begin
          red_q   <= flash_phase;
          green_q <= flash_phase;
        end
        `SSF_PRIO_DELIVERY:  begin
          red_q   <= flash_phase;
          green_q <= !flash_phase;
        end
        `SSF_PRIO_SERVICE:   begin red_q <= 1'b0; green_q <= flash_phase; end
        `SSF_PRIO_READY:     begin red_q <= 1'b0; green_q <= 1'b1;        end
        default:             begin red_q <= 1'b0; green_q <= 1'b0;        end
      endcase
    end
  end

  assign led_prio_out  = prio_q;
  assign led_red_out   = red_q;
  assign led_green_out = green_q;

  // Register bus: address and data are held separately, so either may come
  // first; nothing new is taken while a response waits.
  assign axi_awready_out = !aw_held_q && !bvalid_q;
  assign axi_wready_out  = !w_held_q && !bvalid_q;
  assign do_write        = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= `SSF_ZERO_WORD;
      wstrb_q   <= 4'h0;
    end else begin
      if (axi_awvalid_in && axi_awready_out) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= axi_awaddr_in;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (axi_wvalid_in && axi_wready_out) begin
        w_held_q <= 1'b1;
        wdata_q  <= axi_wdata_in;
        wstrb_q  <= axi_wstrb_in;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bvalid_q  <= 1'b0;
      bresp_q   <= `SSF_RESP_OKAY;
      ack_q     <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      ack_q     <= do_write && is_reg(awaddr_q, `SSF_CTRL_OFFSET) &&
                   wstrb_q[0] && wdata_q[`SSF_CTRL_ACK_BIT];
      restart_q <= do_write && is_reg(awaddr_q, `SSF_CTRL_OFFSET) &&
                   wstrb_q[0] && wdata_q[`SSF_CTRL_RESTART_BIT];
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q  <= is_reg(awaddr_q, `SSF_CTRL_OFFSET) ? `SSF_RESP_OKAY
                                                       : `SSF_RESP_SLVERR;
      end else if (axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign axi_bvalid_out  = bvalid_q;
  assign axi_bresp_out   = bresp_q;
  assign axi_arready_out = !rvalid_q;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rvalid_q <= 1'b0;
      rdata_q  <= `SSF_ZERO_WORD;
      rresp_q  <= `SSF_RESP_OKAY;
    end else if (axi_arvalid_in && axi_arready_out) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `SSF_RESP_OKAY;
      rdata_q  <= `SSF_ZERO_WORD;
      if (is_reg(axi_araddr_in, `SSF_STATUS_OFFSET)) begin
        rdata_q[`SSF_STAT_FLAGS_MSB:`SSF_STAT_FLAGS_LSB] <= flags_q;
        rdata_q[`SSF_STAT_STATE_MSB:`SSF_STAT_STATE_LSB] <= 4'(state_q);
        rdata_q[`SSF_STAT_SUB_MSB:`SSF_STAT_SUB_LSB]     <= 2'(sub_q);
      end else if (is_reg(axi_araddr_in, `SSF_LED_OFFSET)) begin
        rdata_q[`SSF_LED_PRIO_MSB:`SSF_LED_PRIO_LSB] <= prio_q;
        rdata_q[`SSF_LED_RED_BIT]                    <= red_q;
        rdata_q[`SSF_LED_GREEN_BIT]                  <= green_q;
      end else if (!is_reg(axi_araddr_in, `SSF_CTRL_OFFSET)) begin
        rresp_q <= `SSF_RESP_SLVERR;
      end
    end else if (axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  assign axi_rvalid_out = rvalid_q;
  assign axi_rdata_out  = rdata_q;
  assign axi_rresp_out  = rresp_q;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  AST_RESET_INIT: assert property (
    $past(sys_rst_in) |-> state_q == ssf_pkg::ST_INIT1 && flags_q == 8'h00)
    else $error("State or flags not cleared by reset.");

  AST_INIT1_WAITS: assert property (
    state_q == ssf_pkg::ST_INIT1 && !selftest_done_in && !selftest_fail_in &&
    !fault && !restart_q |=> state_q == ssf_pkg::ST_INIT1)
    else $error("Left first initialisation before self-test.");

  AST_DELIVERY_ENTRY: assert property (
    state_q == ssf_pkg::ST_PARAM_CHECK && param_present_in && delivery_cond &&
    !fault && !restart_q |=> state_q == ssf_pkg::ST_DELIVERY)
    else $error("Delivery condition not recognised.");

  AST_SERVICE_OFF: assert property (
    state_q == ssf_pkg::ST_SERVICE |-> safe_outputs_off_out &&
    !stage_enable_permit_out && !brake_enable_permit_out)
    else $error("Enable permitted in service.");

  AST_OP_FROM_COMM: assert property (
    state_q == ssf_pkg::ST_OPERATION && $past(state_q) !=
    ssf_pkg::ST_OPERATION |-> $past(state_q) == ssf_pkg::ST_COMM &&
    $past(set_valid) && !$past(fault))
    else $error("Operation entered without valid start-up.");

  AST_ERR_STAYS: assert property (
    state_q == ssf_pkg::ST_SYS_ERROR && !(ack_q && !fault) && !restart_q
    |=> state_q == ssf_pkg::ST_SYS_ERROR)
    else $error("System error left without acknowledge.");

  AST_CHECKSUM: assert property (
    checksum_fail_in && !restart_q |=> state_q == ssf_pkg::ST_SYS_ERROR)
    else $error("Checksum failure did not reach system error.");

  AST_VIOLATED_HOLD: assert property (
    state_q == ssf_pkg::ST_OPERATION && sub_q == ssf_pkg::SUB_VIOLATED &&
    !ack_q && !fault && !restart_q |=> sub_q == ssf_pkg::SUB_VIOLATED)
    else $error("Violation left without acknowledge.");

  AST_SSR_FLAG: assert property (
    ##1 safe_state_reached_flag_out == $past(any_req && all_safe))
    else $error("Safe-reached flag wrong.");

  AST_LED_ERROR: assert property (
    system_error_flag_out |=> led_prio_out == `SSF_PRIO_ERROR ##1
    led_red_out == $past(flash_phase) && !led_green_out)
    else $error("System error not shown as red flash.");

  AST_BRESP_HOLD: assert property (
    axi_bvalid_out && !axi_bready_in |=> axi_bvalid_out && $stable(bresp_q))
    else $error("Write response dropped before ready.");

endmodule

// ---- design/ssf_map.svh ----
// Offsets, field positions, reset values and timing of the status block.
`ifndef SSF_MAP_SVH
`define SSF_MAP_SVH

`define SSF_ADDR_W           8
`define SSF_CTRL_OFFSET      8'h00
`define SSF_STATUS_OFFSET    8'h04
`define SSF_LED_OFFSET       8'h08

`define SSF_CTRL_ACK_BIT     0
`define SSF_CTRL_RESTART_BIT 1

`define SSF_STAT_FLAGS_LSB   0
`define SSF_STAT_FLAGS_MSB   7
`define SSF_STAT_STATE_LSB   8
`define SSF_STAT_STATE_MSB   11
`define SSF_STAT_SUB_LSB     12
`define SSF_STAT_SUB_MSB     13

`define SSF_LED_PRIO_LSB     0
`define SSF_LED_PRIO_MSB     2
`define SSF_LED_RED_BIT      4
`define SSF_LED_GREEN_BIT    5

`define SSF_RESP_OKAY        2'h0
`define SSF_RESP_SLVERR      2'h2
`define SSF_FLAGS_RESET      8'h00
`define SSF_ZERO_WORD        32'h0000_0000

`define SSF_PRIO_ERROR       3'h7
`define SSF_PRIO_VIOLATED    3'h6
`define SSF_PRIO_SAFE        3'h5
`define SSF_PRIO_REQUESTED   3'h4
`define SSF_PRIO_DELIVERY    3'h3
`define SSF_PRIO_SERVICE     3'h2
`define SSF_PRIO_READY       3'h1
`define SSF_PRIO_OFF         3'h0

`define SSF_CLK_HZ           50000000
`define SSF_FLASH_HZ         3
`define SSF_FLASH_HALF_CYCLES (`SSF_CLK_HZ / (2 * `SSF_FLASH_HZ))

`endif

// ---- design/ssf_pkg.sv ----
// Types of the safety status state machine.
package ssf_pkg;

  typedef enum logic [3:0] {
    ST_INIT1,
    ST_PARAM_CHECK,
    ST_SERVICE,
    ST_DELIVERY,
    ST_INIT2,
    ST_COMM,
    ST_OPERATION,
    ST_SYS_ERROR
  } top_state_t;

  typedef enum logic [1:0] {
    SUB_READY,
    SUB_REQUESTED,
    SUB_SAFE_REACHED,
    SUB_VIOLATED
  } sub_state_t;

endpackage

// ---- design/led_flasher.sv ----
// Free-running divider that gives all flashing LED patterns one phase.
`timescale 1ns/100ps
module led_flasher #(
  parameter int HALF_CYCLES = 8333333
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  output logic      flash_phase_out
);

  localparam int CW = $clog2(HALF_CYCLES + 1);

  logic [CW-1:0] count_q;
  logic          phase_q;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      count_q <= '0;
      phase_q <= 1'b0;
    end else if (count_q == CW'(HALF_CYCLES - 1)) begin
      count_q <= '0;
      phase_q <= ~phase_q;
    end else begin
      count_q <= count_q + CW'(1);
    end
  end

  assign flash_phase_out = phase_q;

endmodule

// ---- bench/drive_unit_model.sv ----
// Far-side model of the drive unit: driver supply and link readiness.
`timescale 1ns/100ps
module drive_unit_model (
  input  wire logic clk_in,
  input  wire logic supply_on_in,
  output logic      pulse_block_enabled_out = 1'b0,
  output logic      comm_up_out = 1'b0
);
  always_ff @(posedge clk_in) begin
    pulse_block_enabled_out <= supply_on_in;
  end
  always_ff @(posedge clk_in) begin
    comm_up_out <= 1'b1;
  end
endmodule

// ---- bench/safety_status_fsm_led_tb.sv ----
// Register-level bench of the safety status block.
`timescale 1ns/100ps
module safety_status_fsm_led_tb;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0;
  logic arv = 1'b0, rre = 1'b0, sd = 1'b0, sfl = 1'b0, pp = 1'b1;
  logic av = 1'b1, sv = 1'b1, did = 1'b0, cks = 1'b0, ses = 1'b0;
  logic i2 = 1'b1, sf = 1'b0, eaw = 1'b0, ew = 1'b0, vw = 1'b0;
  logic sup = 1'b1, awr, wr, bv, arr, rv, pbe, cup, so, sp, bp, lr, lg;
  logic [2:0] lp;
  logic [7:0] aa = 8'h00, ra = 8'h00, frq = 8'h00, fsa = 8'h00, flg;
  logic [31:0] wd = 32'h0000_0000, rd, s;
  logic [1:0] br, rr, r;
  int error_cnt = 0, check_count = 0;
  always #10 clk = ~clk;
  drive_unit_model drive_unit_model_i (.clk_in(clk), .supply_on_in(sup),
    .pulse_block_enabled_out(pbe), .comm_up_out(cup));
  safety_status_fsm_led #(.HALF_CYCLES(4)) safety_status_fsm_led_i (
    .clk_in(clk), .sys_rst_in(rst), .axi_awvalid_in(awv),
    .axi_awready_out(awr), .axi_awaddr_in(aa), .axi_wvalid_in(wv),
    .axi_wready_out(wr), .axi_wdata_in(wd), .axi_wstrb_in(4'hF),
    .axi_bvalid_out(bv), .axi_bready_in(bre), .axi_bresp_out(br),
    .axi_arvalid_in(arv), .axi_arready_out(arr), .axi_araddr_in(ra),
    .axi_rvalid_out(rv), .axi_rready_in(rre), .axi_rdata_out(rd),
    .axi_rresp_out(rr), .selftest_done_in(sd), .selftest_fail_in(sfl),
    .param_present_in(pp), .all_params_validated_in(av),
    .set_validated_in(sv), .delivery_id_in(did), .checksum_fail_in(cks),
    .param_session_in(ses), .init2_done_in(i2), .comm_up_in(cup),
    .sys_fault_in(sf), .err_above_warn_in(eaw), .err_warn_in(ew),
    .viol_err_above_warn_in(vw), .func_request_in(frq),
    .func_safe_in(fsa), .pulse_block_enabled_in(pbe),
    .ready_no_request_flag_out(flg[0]), .service_needed_flag_out(flg[1]),
    .function_requested_flag_out(flg[2]),
    .safe_state_reached_flag_out(flg[3]), .system_error_flag_out(flg[4]),
    .condition_violated_flag_out(flg[5]), .warning_flag_out(flg[6]),
    .power_stage_enable_flag_out(flg[7]), .safe_outputs_off_out(so),
    .stage_enable_permit_out(sp), .brake_enable_permit_out(bp),
    .led_prio_out(lp), .led_red_out(lr), .led_green_out(lg));
  task automatic ck(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awv <= 1'b1; wv <= 1'b1; aa <= a; wd <= d; bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = br;
    bre <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    arv <= 1'b1; ra <= a; rre <= 1'b1;
    do begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    s = rd;
    r = rr;
    rre <= 1'b0;
  endtask
  // Flags settle in one edge and LED colours in three, so four is safe.
  task automatic wt(input logic [7:0] a);
    repeat (4) @(posedge clk);
    rreg(a);
  endtask
  task automatic go(input logic [3:0] e);
    int i = 0;
    do begin rreg(8'h04); i++; end while (i < 40 && s[11:8] !== e);
    ck(s[11:8], e);
  endtask
  // Eight samples span one whole flash period when the half period is four.
  task automatic fl(input int e);
    int n = 0;
    repeat (8) begin
      @(posedge clk);
      n += lr + 8 * lg;
    end
    ck(n, e);
  endtask
  task automatic complete_run;
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk);
    ck(flg, 8'h00);
    rst <= 1'b0;
    @(posedge clk);
    rreg(8'h04);
    ck(s[11:8], 4'h0);
    sd <= 1'b1;
    go(4'h6);
    ck({sp, bp, so, s[0], s[7]}, 5'h1B);
    rreg(8'h08);
    ck(s, 32'h0000_0021);
    frq <= 8'h05;
    wt(8'h04);
    ck(s[13:0], 14'h1684);
    rreg(8'h08);
    ck(s[2:0], 3'h4);
    fsa <= 8'h01;
    wt(8'h04);
    ck(s[13:0], 14'h1684);
    fsa <= 8'h05;
    wt(8'h04);
    ck(s[13:0], 14'h268C);
    rreg(8'h08);
    ck(s, 32'h0000_0035);
    ck({lg, lr, lp}, 5'h1D);
    vw <= 1'b1;
    wt(8'h04);
    ck({s[13:12], s[5]}, 3'h7);
    rreg(8'h08);
    ck(s, 32'h0000_0016);
    vw <= 1'b0; frq <= 8'h00; fsa <= 8'h00;
    wt(8'h04);
    ck({s[13:12], s[5], s[2]}, 4'hC);
    wreg(8'h00, 32'h0000_0001);
    wt(8'h04);
    ck({r, s[13:12]}, 4'h0);
    ew <= 1'b1;
    wt(8'h04);
    ck({s[6], s[4], s[0]}, 3'h5);
    ew <= 1'b0; eaw <= 1'b1;
    wt(8'h04);
    ck({s[6], s[4], s[0]}, 3'h2);
    eaw <= 1'b0; sup <= 1'b0;
    wt(8'h04);
    ck(s[7], 1'b0);
    sf <= 1'b1;
    go(4'h7);
    sf <= 1'b0;
    wt(8'h08);
    ck(s[2:0], 3'h7);
    fl(4);
    rreg(8'h04);
    ck(s[11:8], 4'h7);
    wreg(8'h00, 32'h0000_0001);
    go(4'h6);
    cks <= 1'b1;
    go(4'h7);
    cks <= 1'b0; sv <= 1'b0; did <= 1'b1; sup <= 1'b1;
    wreg(8'h00, 32'h0000_0002);
    go(4'h3);
    wt(8'h08);
    ck(s[2:0], 3'h3);
    fl(36);
    ses <= 1'b1; did <= 1'b0; sup <= 1'b0;
    go(4'h2);
    ck({so, sp, bp, s[1]}, 4'h9);
    rreg(8'h08);
    ck(s[2:0], 3'h2);
    fl(32);
    ses <= 1'b0; sv <= 1'b1;
    go(4'h6);
    sd <= 1'b0; rst <= 1'b1;
    repeat (2) @(posedge clk);
    ck({flg, so, sp}, 10'h002);
    rst <= 1'b0;
    rreg(8'h04);
    ck(s[11:8], 4'h0);
    rreg(8'h0C);
    ck({r, s}, {2'h2, 32'h0000_0000});
    wreg(8'h04, 32'h0000_0001);
    ck(r, 2'h2);
    complete_run();
  end
endmodule
